//--- core_ptr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module core_ptr_regs (
   input  wire logic                      mclk_i,
   input  wire logic                      sys_rst_i,
   input  wire core_ptr_pkg::dop_t        op_i,
   input  wire logic                      ext_i,
   input  wire core_ptr_pkg::daddr_t      addr_i,
   input  wire logic [7:0]                wdata_i,
   input  wire logic                      alu_we_i,
   input  wire logic [7:0]                alu_res_i,
   input  wire logic                      branch_i,
   input  wire logic [core_ptr_pkg::PC_W-1:0] branch_tgt_i,
   input  wire logic                      seq_i,
   input  wire logic                      tbl_rd_i,
   input  wire logic [15:0]               tbl_word_i,
   output logic [7:0]                     rdata_o,
   output logic [7:0]                     acc_o,
   output logic [core_ptr_pkg::PC_W:0]    pc_o,
   output logic [15:0]                    tbl_addr_o,
   output logic                           dummy_o,
   output logic                           bank_o
);
   import core_ptr_pkg::*;
   core_ptr_if mem ();
   logic [7:0] ptr_zero, ptr_b_low, ptr_b_sect, ptr_c_low, ptr_c_sect;
   logic [7:0] tbl_low, tbl_high, tbl_result;
   daddr_t     eff_addr;
   daddr_t     direct_addr;
   logic [7:0] sel_rd, next_val;
   logic       to_gp, pcl_write, sect0;

   gp_data_ram u_ram (.mclk_i(mclk_i), .mem(mem));

   // resolve windows to pointed addresses; windows live in sector 0 only
   always_comb begin
      direct_addr = ext_i ? addr_i : {{SECT_W{1'b0}}, addr_i[7:0]};
      eff_addr = direct_addr;
      if (direct_addr[SECT_W+7:8] == '0) begin
         case (direct_addr[7:0])
            ADDR_WINDOW_A: eff_addr = {{SECT_W{1'b0}}, ptr_zero};
            ADDR_WINDOW_B: eff_addr = {ptr_b_sect[SECT_W-1:0], ptr_b_low};
            ADDR_WINDOW_C: eff_addr = {ptr_c_sect[SECT_W-1:0], ptr_c_low};
            default: ;
         endcase
      end
   end

   // read mux over special and general locations
   always_comb begin
      to_gp = (eff_addr[7:0] >= ADDR_GP_BASE);
      sect0 = (eff_addr[SECT_W+7:8] == '0);
      case (eff_addr[7:0])
         ADDR_PTR_ZERO:   sel_rd = ptr_zero;
         ADDR_PTR_B_LOW:  sel_rd = ptr_b_low;
         ADDR_PTR_B_SECT: sel_rd = ptr_b_sect;
         ADDR_PTR_C_LOW:  sel_rd = ptr_c_low;
         ADDR_PTR_C_SECT: sel_rd = ptr_c_sect;
         ADDR_ACC:        sel_rd = acc_o;
         ADDR_PC_LOW:     sel_rd = pc_o[7:0];
         ADDR_TBL_LOW:    sel_rd = tbl_low;
         ADDR_TBL_HIGH:   sel_rd = tbl_high;
         ADDR_TBL_RESULT: sel_rd = tbl_result;
         ADDR_BANK_SEL:   sel_rd = {7'h00, bank_o};
         default:         sel_rd = to_gp ? mem.gp_rdata : EMPTY_READ;
      endcase
      // special registers exist in sector 0 only; other sectors read zero there
      if (!to_gp && !sect0) begin
         sel_rd = EMPTY_READ;
      end
      case (op_i)
         OP_INC:  next_val = sel_rd + 8'h01;
         OP_DEC:  next_val = sel_rd - 8'h01;
         default: next_val = wdata_i;
      endcase
   end

   // table read low byte goes to the user location
   assign mem.gp_addr  = eff_addr;
   assign mem.gp_we    = to_gp && ((op_i == OP_WRITE) || (op_i == OP_INC)
                         || (op_i == OP_DEC) || tbl_rd_i);
   assign mem.gp_wdata = tbl_rd_i ? tbl_word_i[7:0] : next_val;

   wire wr_any = (op_i == OP_WRITE) || (op_i == OP_INC) || (op_i == OP_DEC);
   wire wr_sfr = wr_any && !to_gp && sect0 && !tbl_rd_i;
   assign pcl_write = wr_sfr && eff_addr[7:0] == ADDR_PC_LOW;

   // pointer storage
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ptr_zero <= RST_BYTE;
         ptr_b_low <= RST_BYTE;
         ptr_b_sect <= RST_BYTE;
         ptr_c_low <= RST_BYTE;
         ptr_c_sect <= RST_BYTE;
      end else if (wr_sfr) begin
         case (eff_addr[7:0])
            ADDR_PTR_ZERO:   ptr_zero <= next_val;
            ADDR_PTR_B_LOW:  ptr_b_low <= next_val;
            ADDR_PTR_B_SECT: ptr_b_sect <= next_val;
            ADDR_PTR_C_LOW:  ptr_c_low <= next_val;
            ADDR_PTR_C_SECT: ptr_c_sect <= next_val;
            default: ;
         endcase
      end
   end

   // accumulator takes alu results or moved data
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         acc_o <= RST_BYTE;
      end else if (alu_we_i) begin
         acc_o <= alu_res_i;
      end else if (wr_sfr && eff_addr[7:0] == ADDR_ACC) begin
         acc_o <= next_val;
      end
   end

   // bank select bit
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         bank_o <= 1'b0;
      end else if (wr_sfr && eff_addr[7:0] == ADDR_BANK_SEL) begin
         bank_o <= next_val[BANK_BIT_POS];
      end
   end

   // table pointer pair and high result
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tbl_low <= RST_BYTE;
         tbl_high <= RST_BYTE;
         tbl_result <= RST_BYTE;
      end else begin
         if (wr_sfr && eff_addr[7:0] == ADDR_TBL_LOW) begin
            tbl_low <= next_val;
         end
         if (wr_sfr && eff_addr[7:0] == ADDR_TBL_HIGH) begin
            tbl_high <= next_val;
         end
         if (tbl_rd_i) begin
            tbl_result <= tbl_word_i[15:8];
         end else if (wr_sfr && eff_addr[7:0] == ADDR_TBL_RESULT) begin
            tbl_result <= next_val;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tbl_addr_o <= 16'h0000;
      end else begin
         tbl_addr_o <= {tbl_high, tbl_low};
      end
   end

   // program counter: page jump, bank branch, sequential step
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pc_o <= '0;
      end else if (pcl_write) begin
         pc_o <= {pc_o[PC_W:8], next_val};
      end else if (branch_i) begin
         pc_o <= {bank_o, branch_tgt_i};
      end else if (seq_i && !dummy_o) begin
         pc_o <= pc_o + 1'b1;
      end
   end

   // one stall cycle after a pc low load
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         dummy_o <= 1'b0;
      end else begin
         dummy_o <= pcl_write;
      end
   end

   // registered read data
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rdata_o <= EMPTY_READ;
      end else if (op_i == OP_READ) begin
         rdata_o <= sel_rd;
      end
   end

   property p_win_zero;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (op_i == OP_READ && !ext_i && addr_i[7:0] == ADDR_WINDOW_A && ptr_zero == ADDR_WINDOW_A)
      |=> rdata_o == EMPTY_READ;
   endproperty
   a_win_zero: assert property (p_win_zero) else $error("window read not zero");
   property p_bank_rd;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (op_i == OP_READ && !ext_i && addr_i[7:0] == ADDR_BANK_SEL) |=> rdata_o[7:1] == 7'h00;
   endproperty
   a_bank_rd: assert property (p_bank_rd) else $error("bank upper bits nonzero");
   property p_dummy;
      @(posedge mclk_i) disable iff (sys_rst_i)
      pcl_write |=> dummy_o ##1 ($past(pcl_write) || $past(branch_i) || $stable(pc_o));
   endproperty
   a_dummy: assert property (p_dummy) else $error("dummy cycle wrong");
   property p_page;
      @(posedge mclk_i) disable iff (sys_rst_i)
      pcl_write |=> pc_o[PC_W:8] == $past(pc_o[PC_W:8]) && pc_o[7:0] == $past(next_val);
   endproperty
   a_page: assert property (p_page) else $error("pc low jump left page");
   property p_branch;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (branch_i && !pcl_write) |=> pc_o[PC_W] == $past(bank_o);
   endproperty
   a_branch: assert property (p_branch) else $error("branch bank wrong");
   property p_tbl;
      @(posedge mclk_i) disable iff (sys_rst_i)
      tbl_rd_i |=> tbl_result == $past(tbl_word_i[15:8]);
   endproperty
   a_tbl: assert property (p_tbl) else $error("table high byte wrong");
   property p_ptr;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (op_i == OP_INC && !ext_i && addr_i[7:0] == ADDR_PTR_ZERO) |=> ptr_zero == $past(ptr_zero) + 8'h01;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer increment failed");
   property p_acc;
      @(posedge mclk_i) disable iff (sys_rst_i)
      alu_we_i |=> acc_o == $past(alu_res_i);
   endproperty
   a_acc: assert property (p_acc) else $error("acc missed alu result");
endmodule
`default_nettype wire

//--- core_ptr_pkg.sv
package core_ptr_pkg;
   // special purpose locations in sector 0
   localparam logic [7:0] ADDR_WINDOW_A   = 8'h00;
   localparam logic [7:0] ADDR_PTR_ZERO   = 8'h01;
   localparam logic [7:0] ADDR_WINDOW_B   = 8'h02;
   localparam logic [7:0] ADDR_PTR_B_LOW  = 8'h03;
   localparam logic [7:0] ADDR_PTR_B_SECT = 8'h04;
   localparam logic [7:0] ADDR_ACC        = 8'h05;
   localparam logic [7:0] ADDR_PC_LOW     = 8'h06;
   localparam logic [7:0] ADDR_TBL_LOW    = 8'h07;
   localparam logic [7:0] ADDR_TBL_RESULT = 8'h08;
   localparam logic [7:0] ADDR_TBL_HIGH   = 8'h09;
   localparam logic [7:0] ADDR_BANK_SEL   = 8'h0b;
   localparam logic [7:0] ADDR_WINDOW_C   = 8'h0c;
   localparam logic [7:0] ADDR_PTR_C_LOW  = 8'h0d;
   localparam logic [7:0] ADDR_PTR_C_SECT = 8'h0e;
   // first general purpose location of a sector
   localparam logic [7:0] ADDR_GP_BASE    = 8'h80;
   // sector field width and program counter width below the bank bit
   localparam int         SECT_W          = 1;
   localparam int         PC_W            = 13;
   localparam int         BANK_BIT_POS    = 0;
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [7:0] EMPTY_READ      = 8'h00;
   localparam int         PAGE_FILL_CYC   = 1;
   typedef logic [SECT_W+7:0] daddr_t;
   typedef enum logic [2:0] {OP_NONE, OP_READ, OP_WRITE, OP_INC, OP_DEC} dop_t;
endpackage

//--- core_ptr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface core_ptr_if;
   import core_ptr_pkg::*;
   logic       gp_we;
   daddr_t     gp_addr;
   logic [7:0] gp_wdata;
   logic [7:0] gp_rdata;
   modport regs (output gp_rdata, input gp_we, input gp_addr, input gp_wdata);
   modport core (input gp_rdata, output gp_we, output gp_addr, output gp_wdata);
endinterface
`default_nettype wire

//--- gp_data_ram.sv
`timescale 1ns/10ps
`default_nettype none
module gp_data_ram (
   input  wire logic mclk_i,
   core_ptr_if.regs  mem
);
   import core_ptr_pkg::*;
   // one byte per full data address: sector bits plus low byte
   logic [7:0] store [0:(2**(SECT_W+8))-1];
   // general purpose storage, combinational read
   always_ff @(posedge mclk_i) begin
      if (mem.gp_we) begin
         store[mem.gp_addr] <= mem.gp_wdata;
      end
   end
   assign mem.gp_rdata = store[mem.gp_addr];
endmodule
`default_nettype wire

//--- core_ptr_prog_model.sv
`timescale 1ns/10ps
`default_nettype none
// program memory seen by the table read path; every address gives a distinct word
module core_ptr_prog_model (
   input  wire logic [15:0] addr_i,
   output logic      [15:0] word_o
);
   // word pattern differs in both bytes so swapped halves show up
   assign word_o = addr_i ^ 16'ha5c3;
endmodule
`default_nettype wire

//--- core_ptr_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
   $display("[ERR] %0t mismatch got %h want %h", $time, a, b); end end
module core_ptr_regs_test;
   import core_ptr_pkg::*;
   typedef struct packed {dop_t op; daddr_t a; logic [7:0] d; logic [7:0] e;} row_t;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   dop_t        op_i = OP_NONE;
   logic        ext_i = 1'b0;
   daddr_t      addr_i = '0;
   logic [7:0]  wdata_i = 8'h00;
   logic        alu_we_i = 1'b0;
   logic [7:0]  alu_res_i = 8'h3e;
   logic        branch_i = 1'b0;
   logic [12:0] branch_tgt_i = 13'h1234;
   logic        seq_i = 1'b0;
   logic        tbl_rd_i = 1'b0;
   wire  [15:0] tbl_word_i;
   logic [7:0]  rdata_o, acc_o;
   logic [13:0] pc_o;
   logic [15:0] tbl_addr_o;
   logic        dummy_o, bank_o;
   int          num_errors = 0;
   int          compares = 0;
   int          cycles = 0;
   // plain cases: access, expected read data (reads only)
   row_t rows [0:28] = '{
      '{OP_WRITE, 9'h001, 8'h85, 8'h00}, '{OP_WRITE, 9'h000, 8'h5a, 8'h00},
      '{OP_READ,  9'h085, 8'h00, 8'h5a}, '{OP_READ,  9'h000, 8'h00, 8'h5a},
      '{OP_READ,  9'h001, 8'h00, 8'h85}, '{OP_WRITE, 9'h185, 8'hc3, 8'h00},
      '{OP_READ,  9'h000, 8'h00, 8'h5a}, '{OP_READ,  9'h185, 8'h00, 8'hc3},
      '{OP_INC,   9'h001, 8'h00, 8'h00}, '{OP_READ,  9'h001, 8'h00, 8'h86},
      '{OP_DEC,   9'h001, 8'h00, 8'h00}, '{OP_READ,  9'h001, 8'h00, 8'h85},
      '{OP_WRITE, 9'h004, 8'h01, 8'h00}, '{OP_WRITE, 9'h003, 8'hf0, 8'h00},
      '{OP_WRITE, 9'h002, 8'h3c, 8'h00}, '{OP_READ,  9'h1f0, 8'h00, 8'h3c},
      '{OP_WRITE, 9'h00e, 8'h00, 8'h00}, '{OP_WRITE, 9'h00d, 8'h90, 8'h00},
      '{OP_WRITE, 9'h00c, 8'h77, 8'h00}, '{OP_READ,  9'h090, 8'h00, 8'h77},
      '{OP_INC,   9'h00c, 8'h00, 8'h00}, '{OP_READ,  9'h090, 8'h00, 8'h78},
      '{OP_WRITE, 9'h001, 8'h00, 8'h00}, '{OP_WRITE, 9'h000, 8'h99, 8'h00},
      '{OP_READ,  9'h000, 8'h00, 8'h00}, '{OP_READ,  9'h00a, 8'h00, 8'h00},
      '{OP_READ,  9'h020, 8'h00, 8'h00}, '{OP_WRITE, 9'h00b, 8'hff, 8'h00},
      '{OP_READ,  9'h00b, 8'h00, 8'h01}};
   core_ptr_regs i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .op_i(op_i), .ext_i(ext_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .alu_we_i(alu_we_i), .alu_res_i(alu_res_i),
      .branch_i(branch_i), .branch_tgt_i(branch_tgt_i), .seq_i(seq_i), .tbl_rd_i(tbl_rd_i),
      .tbl_word_i(tbl_word_i), .rdata_o(rdata_o), .acc_o(acc_o), .pc_o(pc_o),
      .tbl_addr_o(tbl_addr_o), .dummy_o(dummy_o), .bank_o(bank_o));
   core_ptr_prog_model i_prog (.addr_i(tbl_addr_o), .word_o(tbl_word_i));
   // clock generator
   always #5 mclk_i = ~mclk_i;
   // one request cycle; strobes are {alu, branch, table, step}, step is left for the caller
   task automatic go(input dop_t op, input daddr_t a, input logic [7:0] d, input logic [3:0] s);
      @(posedge mclk_i);
      op_i <= op;
      ext_i <= a[8];
      addr_i <= a;
      wdata_i <= d;
      {alu_we_i, branch_i, tbl_rd_i, seq_i} <= s;
      @(posedge mclk_i);
      op_i <= OP_NONE;
      {alu_we_i, branch_i, tbl_rd_i} <= 3'b000;
      #1;
   endtask
   // verdict and end of run
   task automatic test_done();
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      #1;
      `CHK({rdata_o, acc_o, pc_o, tbl_addr_o, dummy_o, bank_o}, 48'h0)
      // table of plain accesses
      foreach (rows[i]) begin
         go(rows[i].op, rows[i].a, rows[i].d, 4'b0000);
         if (rows[i].op == OP_READ) `CHK(rdata_o, rows[i].e)
      end
      `CHK(bank_o, 1'b1)
      go(OP_NONE, 9'h000, 8'h00, 4'b0100);
      `CHK(pc_o, 14'h3234)
      // low byte write while stepping: page kept, one dead cycle, then step resumes
      go(OP_WRITE, 9'h006, 8'h56, 4'b0001);
      `CHK({pc_o, dummy_o}, {14'h3256, 1'b1})
      @(posedge mclk_i);
      #1;
      `CHK({pc_o, dummy_o}, {14'h3256, 1'b0})
      @(posedge mclk_i);
      seq_i <= 1'b0;
      #1;
      `CHK(pc_o, 14'h3257)
      // table pointer pair then a table read into 0x80
      go(OP_WRITE, 9'h007, 8'h34, 4'b0000);
      go(OP_WRITE, 9'h009, 8'h12, 4'b0000);
      go(OP_NONE, 9'h000, 8'h00, 4'b0000);
      `CHK(tbl_addr_o, 16'h1234)
      go(OP_NONE, 9'h080, 8'h00, 4'b0010);
      go(OP_READ, 9'h008, 8'h00, 4'b0000);
      `CHK(rdata_o, 8'hb7)
      go(OP_READ, 9'h080, 8'h00, 4'b0000);
      `CHK(rdata_o, 8'hf7)
      go(OP_INC, 9'h007, 8'h00, 4'b0000);
      go(OP_NONE, 9'h000, 8'h00, 4'b0000);
      `CHK(tbl_addr_o, 16'h1235)
      // accumulator: plain write, then alu result beating a write
      go(OP_WRITE, 9'h005, 8'h11, 4'b0000);
      `CHK(acc_o, 8'h11)
      go(OP_WRITE, 9'h005, 8'h22, 4'b1000);
      `CHK(acc_o, 8'h3e)
      go(OP_READ, 9'h005, 8'h00, 4'b0000);
      `CHK(rdata_o, 8'h3e)
      // sector one holds no special registers at the accumulator's offset
      go(OP_READ, 9'h105, 8'h00, 4'b0000);
      `CHK(rdata_o, 8'h00)
      // mid-run reset clears bank, counters and pointers
      @(posedge mclk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      #1;
      `CHK({rdata_o, acc_o, pc_o, tbl_addr_o, dummy_o, bank_o}, 48'h0)
      go(OP_READ, 9'h004, 8'h00, 4'b0000);
      `CHK(rdata_o, 8'h00)
      test_done();
   end
endmodule
`default_nettype wire
